// *** rtl/ccp_value_and_timer_select.v ***
// Register front end and per-channel datapath for four capture/compare/PWM channels
// What this block does
// - Capture mode loads the value byte with the selected timer high byte.
// - Compare mode matches the value byte against the selected timer high byte.
// - PWM with format 0 uses only bits 1:0 as top duty bits.
// - PWM with format 1 uses all eight bits as top duty bits.
// - Timer-select code 11 routes capture/compare to fifth, PWM to sixth timer.
// - Timer-select code 10 routes capture/compare to third, PWM to fourth timer.
// - Code 01 routes to first and second timer; code 00 reserved.
// - Fourth channel timer-select sits in routing bits 7:6.
// - Third channel timer-select sits in routing bits 5:4.
// - Second channel timer-select sits in routing bits 3:2.
// - First channel timer-select sits in bits 1:0; all fields read/write.
`include "ccp_defines.vh"
module ccp_value_and_timer_select #(
    parameter NCH = 4
) (
    // Clock, reset, enable
    input  wire              pclk,
    input  wire              presetn,
    input  wire              clk_en,
    // APB slave
    input  wire              psel,
    input  wire              penable,
    input  wire              pwrite,
    input  wire [11:0]       paddr,
    input  wire [31:0]       pwdata,
    output wire              pready,
    output reg  [31:0]       prdata,
    output wire              pslverr,
    // Timer high bytes
    input  wire [7:0]        first_timer_high_byte,
    input  wire [7:0]        second_timer_high_byte,
    input  wire [7:0]        third_timer_high_byte,
    input  wire [7:0]        fourth_timer_high_byte,
    input  wire [7:0]        fifth_timer_high_byte,
    input  wire [7:0]        sixth_timer_high_byte,
    // Per-channel capture events, one-cycle pulses
    input  wire [NCH-1:0]    capture_event,
    // Per-channel outputs
    output reg  [NCH-1:0]    compare_match,
    output reg  [8*NCH-1:0]  pwm_duty_high,
    output reg  [NCH-1:0]    pwm_high_match
);
    // Routing and mode registers
    reg  [7:0]               channel_timer_routing;
    reg  [3*NCH-1:0]         channel_mode_ctrl;
    reg  [NCH-1:0]           capture_seen;

    // APB access phase control
    reg                      wait_cnt;
    wire                     setup_ok  = psel & penable;
    assign pready  = setup_ok & (wait_cnt == 1'b1);
    wire                     acc_done  = pready & clk_en;
    wire                     wr_done   = acc_done & pwrite;

    wire                     is_value  = (paddr[11:4] == 8'h00) && (paddr[1:0] == 2'h0);
    wire                     is_route  = (paddr == `OFF_ROUTING);
    wire                     is_mode   = (paddr == `OFF_MODE_CTRL);
    wire                     is_status = (paddr == `OFF_STATUS);
    wire                     mapped    = is_value | is_route | is_mode | is_status;
    assign pslverr = pready & ~mapped;

    // One wait state gives the value store time to present registered read data
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wait_cnt <= 1'b0;
        end else if (clk_en) begin
            if (setup_ok && !wait_cnt) begin
                wait_cnt <= 1'b1;
            end else begin
                wait_cnt <= 1'b0;
            end
        end
    end

    // Routed timers per channel
    wire [8*NCH-1:0]         cc_timer;
    wire [8*NCH-1:0]         pwm_timer;
    wire [NCH-1:0]           sel_reserved;
    wire [8*NCH-1:0]         value_all;
    wire [7:0]               store_rd;

    // Capture writes share the store port with the bus; the bus wins a collision
    reg                      st_we;
    reg  [1:0]               st_wa;
    reg  [7:0]               st_wd;
    reg  [NCH-1:0]           cap_pending;
    integer                  k;

    always @* begin
        st_we = 1'b0;
        st_wa = 2'h0;
        st_wd = 8'h00;
        if (wr_done && is_value) begin
            st_we = 1'b1;
            st_wa = paddr[3:2];
            st_wd = pwdata[7:0];
        end else begin
            for (k = NCH - 1; k >= 0; k = k - 1) begin
                if (cap_pending[k]) begin
                    st_we = 1'b1;
                    st_wa = k[1:0];
                    st_wd = cc_timer[8*k +: 8];
                end
            end
        end
    end

    ccp_value_store #(
        .DEPTH (NCH),
        .AW    (2)
    ) u_store (
        .pclk     (pclk),
        .clk_en   (clk_en),
        .wr_en    (st_we),
        .wr_addr  (st_wa),
        .wr_data  (st_wd),
        .rd_addr  (paddr[3:2]),
        .rd_data  (store_rd),
        .all_data (value_all)
    );

    genvar g;
    generate
        for (g = 0; g < NCH; g = g + 1) begin : ch
            wire [2:0] mfield = channel_mode_ctrl[3*g +: 3];
            wire [1:0] channel_operating_mode = mfield[1:0];
            wire       pwm_alignment_format   = mfield[2];
            wire [7:0] vbyte = value_all[8*g +: 8];
            wire [7:0] duty;

            ccp_timer_route u_route (
                .tsel                   (channel_timer_routing[2*g +: 2]),
                .first_timer_high_byte  (first_timer_high_byte),
                .second_timer_high_byte (second_timer_high_byte),
                .third_timer_high_byte  (third_timer_high_byte),
                .fourth_timer_high_byte (fourth_timer_high_byte),
                .fifth_timer_high_byte  (fifth_timer_high_byte),
                .sixth_timer_high_byte  (sixth_timer_high_byte),
                .cc_timer               (cc_timer[8*g +: 8]),
                .pwm_timer              (pwm_timer[8*g +: 8]),
                .sel_reserved           (sel_reserved[g])
            );

            assign duty = pwm_alignment_format ? vbyte : {6'h00, vbyte[1:0]};

            always @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    compare_match[g]      <= 1'b0;
                    pwm_duty_high[8*g +: 8] <= 8'h00;
                    pwm_high_match[g]     <= 1'b0;
                    cap_pending[g]        <= 1'b0;
                    capture_seen[g]       <= 1'b0;
                end else if (clk_en) begin
                    compare_match[g] <= (channel_operating_mode == `MODE_COMPARE) &&
                                        (cc_timer[8*g +: 8] == vbyte);
                    if (channel_operating_mode == `MODE_PWM) begin
                        pwm_duty_high[8*g +: 8] <= duty;
                        pwm_high_match[g]       <= (pwm_timer[8*g +: 8] == duty);
                    end else begin
                        pwm_duty_high[8*g +: 8] <= 8'h00;
                        pwm_high_match[g]       <= 1'b0;
                    end
                    // capture request held until store takes it
                    if (channel_operating_mode == `MODE_CAPTURE && capture_event[g]) begin
                        cap_pending[g] <= 1'b1;
                    end else if (st_we && st_wa == g && !(wr_done && is_value)) begin
                        cap_pending[g] <= 1'b0;
                    end
                    // Sticky capture flag; a new capture wins over a clear
                    if (channel_operating_mode == `MODE_CAPTURE && capture_event[g]) begin
                        capture_seen[g] <= 1'b1;
                    end else if (wr_done && is_status && pwdata[g]) begin
                        capture_seen[g] <= 1'b0;
                    end
                end
            end
        end
    endgenerate

    // Register writes
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            channel_timer_routing <= `ROUTING_RESET;
            channel_mode_ctrl     <= `MODE_CTRL_RESET;
        end else if (clk_en && wr_done) begin
            if (is_route) begin
                channel_timer_routing[`TSEL_CH3_LSB +: 2] <= pwdata[`TSEL_CH3_LSB +: 2];
                channel_timer_routing[`TSEL_CH2_LSB +: 2] <= pwdata[`TSEL_CH2_LSB +: 2];
                channel_timer_routing[`TSEL_CH1_LSB +: 2] <= pwdata[`TSEL_CH1_LSB +: 2];
                channel_timer_routing[`TSEL_CH0_LSB +: 2] <= pwdata[`TSEL_CH0_LSB +: 2];
            end
            if (is_mode) begin
                channel_mode_ctrl <= pwdata[3*NCH-1:0];
            end
        end
    end

    // Read data register, loaded at the edge that ends the wait state, one edge before completion
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
        end else if (clk_en && setup_ok && !wait_cnt && !pwrite) begin
            prdata <= 32'h00000000;
            if (is_route) begin
                prdata <= {24'h000000, channel_timer_routing};
            end else if (is_mode) begin
                prdata <= {20'h00000, channel_mode_ctrl};
            end else if (is_status) begin
                prdata <= {24'h000000, sel_reserved, capture_seen};
            end else if (is_value) begin
                // Store output was loaded from paddr at the setup edge
                prdata <= {24'h000000, store_rd};
            end
        end
    end
endmodule

// *** rtl/ccp_defines.vh ***
// Register offsets, field positions, reset values and mode codes for the channel block
`ifndef CCP_DEFINES_VH
`define CCP_DEFINES_VH

// Byte addresses on the register bus
`define OFF_VALUE_HIGH0   12'h000
`define OFF_VALUE_HIGH1   12'h004
`define OFF_VALUE_HIGH2   12'h008
`define OFF_VALUE_HIGH3   12'h00c
`define OFF_ROUTING       12'h010
`define OFF_MODE_CTRL     12'h014
`define OFF_STATUS        12'h018

// Timer-select field positions inside the routing register
`define TSEL_CH0_LSB      0
`define TSEL_CH1_LSB      2
`define TSEL_CH2_LSB      4
`define TSEL_CH3_LSB      6

// Timer-select codes
`define TSEL_RESERVED     2'h0
`define TSEL_PAIR_A       2'h1
`define TSEL_PAIR_B       2'h2
`define TSEL_PAIR_C       2'h3
`define ROUTING_RESET     8'h55

// Channel operating modes, three bits per channel in the mode register
`define MODE_OFF          2'h0
`define MODE_CAPTURE      2'h1
`define MODE_COMPARE      2'h2
`define MODE_PWM          2'h3
`define MODE_FIELD_W      3
`define MODE_CTRL_RESET   12'h000

// Bus answer delay in cycles
`define APB_WAIT_CYCLES   1

`endif

// *** rtl/ccp_value_store.v ***
// Four-entry store of channel high value bytes with registered read data
module ccp_value_store #(
    parameter DEPTH = 4,
    parameter AW    = 2
) (
    // Clock and enable
    input  wire          pclk,
    input  wire          clk_en,
    // Write port
    input  wire          wr_en,
    input  wire [AW-1:0] wr_addr,
    input  wire [7:0]    wr_data,
    // Read port
    input  wire [AW-1:0] rd_addr,
    output reg  [7:0]    rd_data,
    // Flat view of all entries for the channel logic
    output wire [8*DEPTH-1:0] all_data
);
    reg [7:0] mem [0:DEPTH-1];

    // No reset: the value byte is undefined until software or a capture writes it
    always @(posedge pclk) begin
        if (clk_en) begin
            if (wr_en) begin
                mem[wr_addr] <= wr_data;
            end
            rd_data <= mem[rd_addr];
        end
    end

    genvar g;
    generate
        for (g = 0; g < DEPTH; g = g + 1) begin : flat
            assign all_data[8*g +: 8] = mem[g];
        end
    endgenerate
endmodule

// *** rtl/ccp_timer_route.v ***
// Per-channel timer pair selection: capture/compare timer and PWM timer high bytes
`include "ccp_defines.vh"
module ccp_timer_route (
    // Selection code
    input  wire [1:0] tsel,
    // Timer high bytes
    input  wire [7:0] first_timer_high_byte,
    input  wire [7:0] second_timer_high_byte,
    input  wire [7:0] third_timer_high_byte,
    input  wire [7:0] fourth_timer_high_byte,
    input  wire [7:0] fifth_timer_high_byte,
    input  wire [7:0] sixth_timer_high_byte,
    // Routed results
    output reg  [7:0] cc_timer,
    output reg  [7:0] pwm_timer,
    output reg        sel_reserved
);
    always @* begin
        cc_timer     = first_timer_high_byte;
        pwm_timer    = second_timer_high_byte;
        sel_reserved = 1'b0;
        case (tsel)
            `TSEL_PAIR_C: begin
                cc_timer  = fifth_timer_high_byte;
                pwm_timer = sixth_timer_high_byte;
            end
            `TSEL_PAIR_B: begin
                cc_timer  = third_timer_high_byte;
                pwm_timer = fourth_timer_high_byte;
            end
            `TSEL_PAIR_A: begin
                cc_timer  = first_timer_high_byte;
                pwm_timer = second_timer_high_byte;
            end
            default: begin
                sel_reserved = 1'b1;
            end
        endcase
    end
endmodule

// *** bench/ccp_value_and_timer_select_props.sv ***
// Concurrent checks on the register bus and channel outputs of the routing block
module ccp_value_and_timer_select_props #(
    parameter NCH = 4
) (
    // Clock, reset, enable
    input wire logic             pclk,
    input wire logic             presetn,
    input wire logic             clk_en,
    // Register bus
    input wire logic             psel,
    input wire logic             penable,
    input wire logic             pwrite,
    input wire logic [11:0]      paddr,
    input wire logic [31:0]      pwdata,
    input wire logic             pready,
    input wire logic [31:0]      prdata,
    input wire logic             pslverr,
    // Channel side
    input wire logic [7:0]       first_timer_high_byte,
    input wire logic [NCH-1:0]   capture_event,
    input wire logic [NCH-1:0]   compare_match,
    input wire logic [8*NCH-1:0] pwm_duty_high,
    input wire logic [NCH-1:0]   pwm_high_match
);
    // Shadows of what software wrote, so channel 0 outputs can be predicted
    logic [11:0] mode_sh;
    logic [7:0]  rt_sh;
    logic [7:0]  val0;
    logic        v_ok;
    wire         wr = pready && pwrite && clk_en;
    wire         cc_eq = first_timer_high_byte == val0;
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_sh <= 12'h000;
            rt_sh <= 8'h55;
            v_ok <= 1'b0;
        end else begin
            if (wr && paddr == 12'h014)
                mode_sh <= pwdata[11:0];
            if (wr && paddr == 12'h010)
                rt_sh <= pwdata[7:0];
            if (wr && paddr == 12'h000)
                v_ok <= 1'b1;
            else if (capture_event[0])
                v_ok <= 1'b0;
        end
    end
    // Value bytes have no reset, so this shadow has none either
    always_ff @(posedge pclk) begin
        if (wr && paddr == 12'h000)
            val0 <= pwdata[7:0];
    end
    AST_READY_WAIT: assert property (psel && $rose(penable) |-> !pready ##1 pready)
        else $error("bus answer not after one wait state");
    AST_READY_ONE: assert property (pready |=> !pready)
        else $error("bus answer longer than one cycle");
    AST_SLVERR_MAP: assert property (pready && paddr[1:0] == 2'h0 |-> pslverr == (paddr > 12'h018))
        else $error("error response does not match address map");
    AST_RESET_OUTS: assert property ($rose(presetn) |-> compare_match == 0 && pwm_duty_high == 0)
        else $error("channel outputs not cleared by reset");
    AST_ROUTING_READ: assert property (pready && !pwrite && paddr == 12'h010 |-> prdata[7:0] == rt_sh)
        else $error("routing register read differs from last write");
    AST_CMP_CH0: assert property (clk_en && v_ok && mode_sh[1:0] == 2'h2 && rt_sh[1:0] == 2'h1
        |=> compare_match[0] == $past(cc_eq))
        else $error("channel 0 compare result wrong");
    AST_FMT1_CH0: assert property (clk_en && v_ok && mode_sh[2:0] == 3'h7 |=> pwm_duty_high[7:0] == $past(val0))
        else $error("channel 0 wide duty byte wrong");
    AST_FMT0_CH0: assert property (clk_en && v_ok && mode_sh[2:0] == 3'h3
        |=> pwm_duty_high[7:0] == ($past(val0) & 8'h03))
        else $error("channel 0 narrow duty bits wrong");
    cover property (pready && pslverr);
    cover property (compare_match[0]);
    cover property (|pwm_high_match);
endmodule
bind ccp_value_and_timer_select ccp_value_and_timer_select_props #(.NCH(NCH)) props_u (.*);

// *** bench/ccp_value_and_timer_select_tb.sv ***
// Self-checking bench for the four-channel value and timer routing block
module ccp_value_and_timer_select_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        clk_en = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [7:0]  tmr [0:5] = '{default: 8'h00};
    logic [3:0]  capture_event = 4'h0;
    wire         pready;
    wire         pslverr;
    wire  [31:0] prdata;
    wire  [3:0]  compare_match;
    wire  [3:0]  pwm_high_match;
    wire  [31:0] pwm_duty_high;
    int          num_errors = 0;
    int          check_count = 0;
    int          seed = 46;
    logic [31:0] rd;
    logic        err;
    logic [7:0]  v;

    ccp_value_and_timer_select #(.NCH(4)) dut_u (
        .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .first_timer_high_byte(tmr[0]), .second_timer_high_byte(tmr[1]),
        .third_timer_high_byte(tmr[2]), .fourth_timer_high_byte(tmr[3]),
        .fifth_timer_high_byte(tmr[4]), .sixth_timer_high_byte(tmr[5]),
        .capture_event(capture_event), .compare_match(compare_match),
        .pwm_duty_high(pwm_duty_high), .pwm_high_match(pwm_high_match));

    always #5 pclk = ~pclk;

    function automatic int pwm_idx(input int code);
        return 2 * code - 1;
    endfunction

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // Request held until pready is seen high at a rising edge; read data taken at that edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) num_errors++;
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic setup(input int ch, input logic [2:0] m, input int code);
        logic [7:0] r;
        r = $random(seed);
        r[2*ch +: 2] = code[1:0];
        apb(1'b1, 12'h010, {24'h0, r});
        apb(1'b1, 12'h014, {29'h0, m} << (3 * ch));
    endtask

    // One timer carries the value, the rest its inverse, so a wrong route cannot match
    task automatic set_tmr(input int hit, input logic [7:0] val);
        @(posedge pclk);
        for (int i = 0; i < 6; i++) tmr[i] <= (i == hit) ? val : ~val;
        repeat (3) @(posedge pclk);
        @(negedge pclk);
    endtask

    task automatic do_reset();
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, 12'h010, 32'h0);
        check("routing reset", rd & 32'hff, 32'h55);
    endtask

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    initial begin
        #200000;
        num_errors++;
        wrap_up();
    end

    initial begin
        do_reset();
        repeat (8) begin
            v = $random(seed);
            apb(1'b1, 12'h010, {24'($random(seed)), v});
            apb(1'b0, 12'h010, 32'h0);
            check("routing readback", rd & 32'hff, {24'h0, v});
        end
        apb(1'b1, 12'h01c, 32'hffffffff);
        check("unmapped write error", {31'h0, err}, 32'h1);
        apb(1'b0, 12'h01c, 32'h0);
        check("unmapped read error", {31'h0, err}, 32'h1);
        check("unmapped read data", rd, 32'h0);
        $display("register test done");
        for (int ch = 0; ch < 4; ch++) begin
            for (int code = 1; code < 4; code++) begin
                v = $random(seed);
                apb(1'b1, 12'(4 * ch), {24'h0, v});
                setup(ch, 3'h7, code);
                set_tmr(pwm_idx(code), v);
                check("wide duty", {24'h0, pwm_duty_high[8*ch +: 8]}, {24'h0, v});
                check("pwm route hit", {31'h0, pwm_high_match[ch]}, 32'h1);
                set_tmr(pwm_idx(code) - 1, v);
                check("pwm route miss", {31'h0, pwm_high_match[ch]}, 32'h0);
                setup(ch, 3'h3, code);
                set_tmr(pwm_idx(code), {6'h00, v[1:0]});
                check("narrow duty", {24'h0, pwm_duty_high[8*ch +: 8]}, {30'h0, v[1:0]});
                check("narrow match", {31'h0, pwm_high_match[ch]}, 32'h1);
                setup(ch, 3'h2, code);
                set_tmr(pwm_idx(code) - 1, v);
                check("compare hit", {31'h0, compare_match[ch]}, 32'h1);
                set_tmr(pwm_idx(code), v);
                check("compare miss", {31'h0, compare_match[ch]}, 32'h0);
            end
        end
        $display("routing test done");
        v = $random(seed);
        setup(2, 3'h1, 2);
        set_tmr(2, v);
        @(posedge pclk);
        capture_event <= 4'h4;
        @(posedge pclk);
        capture_event <= 4'h0;
        set_tmr(2, ~v);
        setup(2, 3'h7, 2);
        set_tmr(0, 8'h00);
        check("captured byte", {24'h0, pwm_duty_high[23:16]}, {24'h0, v});
        apb(1'b0, 12'h008, 32'h0);
        check("captured byte read", rd, {24'h0, v});
        // Channels 0 and 3 on the reserved code, channel 2 captured once
        apb(1'b1, 12'h010, 32'h3c);
        apb(1'b0, 12'h018, 32'h0);
        check("status after capture", rd, 32'h94);
        apb(1'b1, 12'h018, 32'h4);
        apb(1'b0, 12'h018, 32'h0);
        check("status after clear", rd, 32'h90);
        $display("capture test done");
        // Low enable must freeze the registered match while the timer moves
        apb(1'b1, 12'h000, 32'h5a);
        setup(0, 3'h7, 1);
        set_tmr(1, 8'h5a);
        check("match before freeze", {31'h0, pwm_high_match[0]}, 32'h1);
        @(posedge pclk);
        clk_en <= 1'b0;
        set_tmr(0, 8'h5a);
        check("frozen match", {31'h0, pwm_high_match[0]}, 32'h1);
        @(posedge pclk);
        clk_en <= 1'b1;
        set_tmr(0, 8'h5a);
        check("released match", {31'h0, pwm_high_match[0]}, 32'h0);
        $display("enable test done");
        do_reset();
        $display("reset test done");
        wrap_up();
    end
endmodule
